// ===== core/pgfl_pkg.sv
// Function
// - First output flag register, seven sources, bit7 zero.
// - First flag sets when enabled source goes invalid.
// - Write one clears first flag when source valid.
// - Second output flag register, same bit order.
// - Second flags set and clear like the first.
// - Both flag registers reset to zero, write one to clear.
// - Rise-delay bit postpones second output rise 11 ms.
// - Control bit 6 admits thermal warning.
// - Control bits 0-5 enable the supply sources.
// - Second enables load from OTP, delay bit zero.
// - Gating setting selects flags or live status.
// - First output uses its own enable register.
// - Polarity setting picks level of good output.
package pgfl_pkg;

   // ************************************************************
   // Register indices; the byte address is four times the index.
   // ************************************************************
   localparam int ADDR_W = 8;
   localparam logic [5:0] IDX_PG_CTRL = 6'h17; // Gating and polarity.
   localparam logic [5:0] IDX_SEL0 = 6'h18; // First output enables.
   localparam logic [5:0] IDX_FLAGS0 = 6'h19; // First output flags.
   localparam logic [5:0] IDX_SEL1 = 6'h1A; // Second output enables.
   localparam logic [5:0] IDX_FLAGS1 = 6'h1B; // Second output flags.

   // ************************************************************
   // Field positions and reset values.
   // ************************************************************
   localparam int SRC_N = 7; // Sources per output.
   localparam int RISE_BIT = 7; // Rise delay in an enable register.
   localparam int POL0_BIT = 0; // First output polarity.
   localparam int GATE0_BIT = 2; // First output latched gating.
   localparam int POL1_BIT = 4; // Second output polarity.
   localparam int GATE1_BIT = 6; // Second output latched gating.
   localparam logic [7:0] PG_CTRL_RST = 8'h02;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************************
   // Timing: rise delay in milliseconds and its cycle count.
   // ************************************************************
   localparam int CLK_HZ = 25000000;
   localparam int RISE_DELAY_MS = 11;
   localparam int RISE_CYCLES = RISE_DELAY_MS * (CLK_HZ / 1000);

   // Rise sequencer states of the second output.
   typedef enum logic [1:0] {
      RISE_LOW = 2'b00,
      RISE_WAIT = 2'b01,
      RISE_HIGH = 2'b10
   } pgfl_rise_e;

   // Output mode bits decoded from the gating and polarity register.
   typedef struct packed {
      logic gate0;
      logic pol0;
      logic gate1;
      logic pol1;
   } pgfl_mode_s;

endpackage

// ===== core/pgfl_top.sv
module pgfl_top #(
   parameter int RISE_CYCLES = pgfl_pkg::RISE_CYCLES,
   parameter logic [6:0] OTP_SEL0 = 7'h00, // One-time defaults.
   parameter logic [6:0] OTP_SEL1 = 7'h00
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [pgfl_pkg::ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [pgfl_pkg::ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic [6:0] source_valid_async,
   output logic first_power_good_output,
   output logic second_power_good_output
);

   // ************************************************************
   // Elaboration checks.
   // ************************************************************
   // The delay counter is 19 bits wide, so the count must fit.
   if (RISE_CYCLES < 1 || RISE_CYCLES >= 524288) begin : g_chk
      $error("RISE_CYCLES out of range");
   end

   // ************************************************************
   // Declarations.
   // ************************************************************
   logic [6:0] vld_meta_q; // First synchroniser stage.
   logic [6:0] vld_q; // Synchronised source valid, 1 means good.
   logic [7:0] pg_ctrl_q; // Gating and polarity register.
   logic [7:0] sel0_q; // First output enables; bit 7 is stored but unused.
   logic [7:0] sel1_q; // Second output enables and rise bit.
   logic [7:0] flags0_q; // First output fault flags.
   logic [7:0] flags1_q; // Second output fault flags.
   logic [7:0] flags0_d;
   logic [7:0] flags1_d;
   logic awready_q; // Write channels taken in this cycle.
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q; // Read address taken in this cycle.
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic [5:0] widx; // Word index of the write.
   logic [5:0] ridx; // Word index of the read.
   logic wr_lane; // Write reaches byte lane zero.
   logic [6:0] cause0; // Enabled sources now invalid, first output.
   logic [6:0] cause1; // Enabled sources now invalid, second output.
   logic [6:0] clr0; // Accepted clear bits, first output.
   logic [6:0] clr1; // Accepted clear bits, second output.
   logic good0; // First output good before polarity.
   logic good1; // Second output good before rise delay.
   pgfl_pkg::pgfl_mode_s mode; // Decoded gating and polarity.
   pgfl_pkg::pgfl_rise_e rise_q;
   pgfl_pkg::pgfl_rise_e rise_d;
   logic [18:0] cnt_q; // Rise delay cycle counter.
   logic first_pg_q; // First output pin register.
   logic second_pg_q; // Second output pin register.

   // True when a word index names a mapped register.
   function automatic logic mapped(input logic [5:0] idx);
      return idx >= pgfl_pkg::IDX_PG_CTRL && idx <= pgfl_pkg::IDX_FLAGS1;
   endfunction

   // A source counts against an output when enabled and invalid.
   function automatic logic [6:0] fault_of(input logic [7:0] sel,
                                           input logic [6:0] vld);
      return sel[6:0] & ~vld;
   endfunction

   // ************************************************************
   // Monitor input synchroniser.
   // ************************************************************
   // Monitor levels are asynchronous; two stages guard metastability.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vld_meta_q <= 7'h7F;
         vld_q <= 7'h7F;
      end else begin
         vld_meta_q <= source_valid_async;
         vld_q <= vld_meta_q;
      end
   end

   // ************************************************************
   // Decode of the write and fault causes.
   // ************************************************************
   assign widx = awaddr[7:2];
   assign ridx = araddr[7:2];
   assign wr_lane = awready_q && wstrb[0];
   assign mode.gate0 = pg_ctrl_q[pgfl_pkg::GATE0_BIT];
   assign mode.pol0 = pg_ctrl_q[pgfl_pkg::POL0_BIT];
   assign mode.gate1 = pg_ctrl_q[pgfl_pkg::GATE1_BIT];
   assign mode.pol1 = pg_ctrl_q[pgfl_pkg::POL1_BIT];
   // Only enabled sources may cause a fault.
   assign cause0 = fault_of(sel0_q, vld_q);
   assign cause1 = fault_of(sel1_q, vld_q);
   // A one clears a flag only while its source is valid again.
   assign clr0 = (wr_lane && widx == pgfl_pkg::IDX_FLAGS0) ?
                 (wdata[6:0] & vld_q) : 7'h00;
   assign clr1 = (wr_lane && widx == pgfl_pkg::IDX_FLAGS1) ?
                 (wdata[6:0] & vld_q) : 7'h00;

   // ************************************************************
   // Fault flags.
   // ************************************************************
   // Clear first, then set, so a new fault beats a clear.
   always_comb begin
      flags0_d = {1'b0, (flags0_q[6:0] & ~clr0) | cause0};
      flags1_d = {1'b0, (flags1_q[6:0] & ~clr1) | cause1};
   end

   // Flags reset to zero and change only as above.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flags0_q <= pgfl_pkg::FLAGS_RST;
         flags1_q <= pgfl_pkg::FLAGS_RST;
      end else begin
         flags0_q <= flags0_d;
         flags1_q <= flags1_d;
      end
   end

   // ************************************************************
   // Control registers.
   // ************************************************************
   // Enables come from one-time defaults, rise delay off.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pg_ctrl_q <= pgfl_pkg::PG_CTRL_RST;
         sel0_q <= {1'b0, OTP_SEL0};
         sel1_q <= {1'b0, OTP_SEL1};
      end else if (wr_lane) begin
         // Address decode of the writable registers.
         if (widx == pgfl_pkg::IDX_PG_CTRL) begin
            pg_ctrl_q <= wdata[7:0];
         end else if (widx == pgfl_pkg::IDX_SEL0) begin
            sel0_q <= wdata[7:0];
         end else if (widx == pgfl_pkg::IDX_SEL1) begin
            sel1_q <= wdata[7:0];
         end
      end
   end

   // ************************************************************
   // Power good status.
   // ************************************************************
   // Gated mode follows the flags, otherwise the live status.
   assign good0 = mode.gate0 ? (flags0_q == 8'h00) : (cause0 == 7'h00);
   assign good1 = mode.gate1 ? (flags1_q == 8'h00) : (cause1 == 7'h00);

   // Rise sequencing of the second output.
   always_comb begin
      rise_d = rise_q;
      case (rise_q)
         pgfl_pkg::RISE_LOW: begin
            // Immediate rise unless the delay bit is set.
            if (good1) begin
               rise_d = sel1_q[pgfl_pkg::RISE_BIT] ?
                        pgfl_pkg::RISE_WAIT : pgfl_pkg::RISE_HIGH;
            end
         end
         pgfl_pkg::RISE_WAIT: begin
            // Any fault during the wait restarts it.
            if (!good1) begin
               rise_d = pgfl_pkg::RISE_LOW;
            end else if (cnt_q == 19'(RISE_CYCLES - 1)) begin
               rise_d = pgfl_pkg::RISE_HIGH;
            end
         end
         pgfl_pkg::RISE_HIGH: begin
            // Falling edges are never delayed.
            if (!good1) begin
               rise_d = pgfl_pkg::RISE_LOW;
            end
         end
         default: begin
            rise_d = pgfl_pkg::RISE_LOW;
         end
      endcase
   end

   // State register and delay counter of the rise sequencer.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rise_q <= pgfl_pkg::RISE_LOW;
         cnt_q <= 19'h00000;
      end else begin
         rise_q <= rise_d;
         cnt_q <= (rise_q == pgfl_pkg::RISE_WAIT) ? cnt_q + 19'h00001
                                                  : 19'h00000;
      end
   end

   // Output pins: good level inverted when polarity is one.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_pg_q <= 1'b0;
         second_pg_q <= 1'b0;
      end else begin
         first_pg_q <= good0 ^ mode.pol0;
         second_pg_q <= (rise_q == pgfl_pkg::RISE_HIGH) ^ mode.pol1;
      end
   end

   // ************************************************************
   // AXI4-Lite write channel.
   // ************************************************************
   // Address and data are taken together, one write at a time.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= pgfl_pkg::RESP_OKAY;
      end else begin
         awready_q <= awvalid && wvalid && !awready_q && !bvalid_q;
         if (awready_q) begin
            // Unmapped addresses answer with a slave error.
            bvalid_q <= 1'b1;
            bresp_q <= mapped(widx) ? pgfl_pkg::RESP_OKAY
                                    : pgfl_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ************************************************************
   // AXI4-Lite read channel.
   // ************************************************************
   // Read data is captured at the address handshake.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= pgfl_pkg::RESP_OKAY;
         rdata_q <= 32'h00000000;
      end else begin
         arready_q <= arvalid && !arready_q && !rvalid_q;
         if (arready_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= pgfl_pkg::RESP_OKAY;
            rdata_q <= 32'h00000000;
            // Address decode; bits above the byte read as zero.
            if (ridx == pgfl_pkg::IDX_PG_CTRL) begin
               rdata_q[7:0] <= pg_ctrl_q;
            end else if (ridx == pgfl_pkg::IDX_SEL0) begin
               rdata_q[7:0] <= sel0_q;
            end else if (ridx == pgfl_pkg::IDX_FLAGS0) begin
               rdata_q[7:0] <= flags0_q;
            end else if (ridx == pgfl_pkg::IDX_SEL1) begin
               rdata_q[7:0] <= sel1_q;
            end else if (ridx == pgfl_pkg::IDX_FLAGS1) begin
               rdata_q[7:0] <= flags1_q;
            end else begin
               rresp_q <= pgfl_pkg::RESP_SLVERR;
            end
         end else if (rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // Every output comes from a flip-flop.
   assign awready = awready_q;
   assign wready = awready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;
   assign first_power_good_output = first_pg_q;
   assign second_power_good_output = second_pg_q;

   // ************************************************************
   // Assertions.
   // ************************************************************
   AST_RSVD_ZERO: assert property (@(posedge aclk)
      disable iff (!aresetn) !flags0_q[7] && !flags1_q[7])
      else $error("reserved flag bit set");

   AST_SET0: assert property (@(posedge aclk) disable iff (!aresetn)
      cause0 != 7'h00 |=> (flags0_q[6:0] & $past(cause0)) == $past(cause0))
      else $error("first flag not set by fault");

   AST_NO_CAUSE0: assert property (@(posedge aclk)
      disable iff (!aresetn) (flags0_q[6:0] & ~$past(flags0_q[6:0])
      & ~$past(cause0)) == 7'h00) else $error("first flag set without cause");

   AST_CLEAR0: assert property (@(posedge aclk)
      disable iff (!aresetn) wr_lane && widx == pgfl_pkg::IDX_FLAGS0 |=>
      (flags0_q[6:0] & $past(wdata[6:0] & vld_q & ~cause0)) == 7'h00)
      else $error("first flag not cleared");

   AST_HOLD_INVALID: assert property (@(posedge aclk)
      disable iff (!aresetn) (flags0_q[6:0] & ~$past(flags0_q[6:0] & ~clr0)
      & ~$past(cause0)) == 7'h00 &&
      ($past(flags0_q[6:0] & ~vld_q) & ~flags0_q[6:0]) == 7'h00)
      else $error("flag cleared while source invalid");

   AST_SET1: assert property (@(posedge aclk) disable iff (!aresetn)
      cause1 != 7'h00 |=> (flags1_q[6:0] & $past(cause1)) == $past(cause1))
      else $error("second flag not set by fault");

   AST_DELAY: assert property (@(posedge aclk) disable iff (!aresetn)
      rise_q == pgfl_pkg::RISE_HIGH && $past(rise_q) == pgfl_pkg::RISE_WAIT
      |-> $past(cnt_q) == 19'(RISE_CYCLES - 1))
      else $error("delayed rise at wrong count");

   AST_IMMEDIATE: assert property (@(posedge aclk)
      disable iff (!aresetn) rise_q == pgfl_pkg::RISE_LOW && good1 &&
      !sel1_q[pgfl_pkg::RISE_BIT] |=> ##1 second_pg_q == !mode.pol1)
      else $error("undelayed rise late");

   AST_GATE0: assert property (@(posedge aclk)
      disable iff (!aresetn) mode.gate0 && flags0_q != 8'h00 |=>
      first_pg_q == $past(mode.pol0)) else $error("gated first output active");

endmodule

// ===== test/pgfl_mon_model.sv
// ************************************************************
// Source monitor model: seven good levels, prompt or slow.
// ************************************************************
module pgfl_mon_model (
   input wire logic aclk,
   input wire logic [6:0] want,
   input wire logic [3:0] lag,
   output logic [6:0] level
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [3:0] cnt; // Cycles spent waiting to follow the target.

   initial begin
      level = 7'h7F;
      cnt = 4'h0;
   end

   // The levels move on the falling edge, so they stay unrelated to
   // the sampling edge, and only after the requested lag has passed.
   always @(negedge aclk) begin
      if (level == want) begin
         cnt <= 4'h0;
      end else if (cnt >= lag) begin
         level <= want;
         cnt <= 4'h0;
      end else begin
         cnt <= cnt + 4'h1;
      end
   end
endmodule

// ===== test/power_good_fault_latch_tb.sv
module power_good_fault_latch_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // Signals, table rows and counters.
   // ************************************************************
   typedef struct packed {
      logic wr;
      logic [7:0] a;
      logic [31:0] d;
      logic [1:0] resp;
   } pgfl_row_s;
   localparam logic [1:0] OK = pgfl_pkg::RESP_OKAY;
   localparam logic [1:0] ERR = pgfl_pkg::RESP_SLVERR;
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, first_pg, second_pg;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb, lag;
   logic [1:0] bresp, rresp;
   logic [6:0] want, level;
   int fails, checks, cyc;
   pgfl_row_s rows [12] = '{
      '{1'b0, 8'h64, 32'h00, OK}, '{1'b0, 8'h6C, 32'h00, OK},
      '{1'b0, 8'h68, 32'h3F, OK}, '{1'b0, 8'h60, 32'h7F, OK},
      '{1'b0, 8'h5C, 32'h02, OK}, '{1'b1, 8'h68, 32'hFF, OK},
      '{1'b0, 8'h68, 32'hFF, OK}, '{1'b1, 8'h64, 32'hFF, OK},
      '{1'b0, 8'h64, 32'h00, OK}, '{1'b1, 8'h70, 32'h00, ERR},
      '{1'b0, 8'h70, 32'h00, ERR}, '{1'b1, 8'h68, 32'h3F, OK}};

   // The clock toggles every half period of 20 ns.
   always #20 aclk = ~aclk;

   pgfl_top #(.RISE_CYCLES(20), .OTP_SEL0(7'h7F), .OTP_SEL1(7'h3F)) dut_u (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .source_valid_async(level), .first_power_good_output(first_pg),
      .second_power_good_output(second_pg));

   pgfl_mon_model mon_u (.aclk(aclk), .want(want), .lag(lag),
      .level(level));

   // ************************************************************
   // Report, compare and bus tasks.
   // ************************************************************
   task automatic conclude;
      $display("Counts: fails=%0d checks=%0d", fails, checks);
      if (fails == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_pin(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t pin %b expected %b", $time, got, exp);
      end
   endtask

   // A write offers address and data together and waits for the answer.
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin @(posedge aclk); n++; end while (awready !== 1'b1 && n < 50);
      chk_pin(wready, 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      while (bvalid !== 1'b1 && n < 50) begin @(posedge aclk); n++; end
      if (n >= 50) begin
         fails++;
         $display("ERROR %0t write timed out", $time);
      end
      chk_data({30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   // A read compares the data only when the answer is expected okay.
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin @(posedge aclk); n++; end while (arready !== 1'b1 && n < 50);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1 && n < 50) begin @(posedge aclk); n++; end
      if (n >= 50) begin
         fails++;
         $display("ERROR %0t read timed out", $time);
      end
      chk_data({30'h0, rresp}, {30'h0, er});
      if (er == OK) chk_data(rdata, ed);
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   // Moves the monitors, then lets them and the synchroniser settle.
   task automatic src(input logic [6:0] w, input int wait_n);
      want <= w;
      repeat (wait_n) @(posedge aclk);
   endtask

   // A hang is cut short after a fixed number of cycles.
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         conclude();
      end
   end

   // ************************************************************
   // Main sequence.
   // ************************************************************
   initial begin
      aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0;
      bready = 1'b0; arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00;
      araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF; lag = 4'h0;
      want = 7'h7F; fails = 0; checks = 0; cyc = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (10) @(posedge aclk);
      chk_pin(first_pg, 1'b1);
      chk_pin(second_pg, 1'b1);
      // Table rows: reset values, write and read back, unmapped place.
      foreach (rows[i]) begin
         if (rows[i].wr)
            wr(rows[i].a, rows[i].d, rows[i].resp);
         else
            rd(rows[i].a, rows[i].d, rows[i].resp);
      end
      // A buck fault sets both flags; a clear while invalid is ignored.
      src(7'h7E, 12);
      chk_pin(first_pg, 1'b0);
      rd(8'h64, 32'h01, OK);
      rd(8'h6C, 32'h01, OK);
      wr(8'h64, 32'h01, OK);
      rd(8'h64, 32'h01, OK);
      src(7'h7F, 12);
      chk_pin(first_pg, 1'b1);
      chk_pin(second_pg, 1'b1);
      wr(8'h64, 32'h00, OK);
      rd(8'h64, 32'h01, OK);
      wr(8'h64, 32'h01, OK);
      rd(8'h64, 32'h00, OK);
      wr(8'h6C, 32'h01, OK);
      rd(8'h6C, 32'h00, OK);
      // Thermal warning: masked on the second output until enabled.
      src(7'h3F, 12);
      rd(8'h64, 32'h40, OK);
      rd(8'h6C, 32'h00, OK);
      wr(8'h68, 32'h7F, OK);
      repeat (6) @(posedge aclk);
      rd(8'h6C, 32'h40, OK);
      src(7'h7F, 12);
      wr(8'h64, 32'h40, OK);
      wr(8'h6C, 32'h40, OK);
      rd(8'h6C, 32'h00, OK);
      // Strobe low on byte zero leaves the register alone.
      wstrb <= 4'hE;
      wr(8'h68, 32'h00, OK);
      wstrb <= 4'hF;
      rd(8'h68, 32'h7F, OK);
      // Latched gating holds the first output inactive until cleared.
      wr(8'h5C, 32'h06, OK);
      src(7'h7B, 12);
      src(7'h7F, 12);
      chk_pin(first_pg, 1'b0);
      wr(8'h64, 32'h04, OK);
      wr(8'h6C, 32'h04, OK);
      repeat (6) @(posedge aclk);
      chk_pin(first_pg, 1'b1);
      // Inverted polarity drives the first output low when good.
      wr(8'h5C, 32'h03, OK);
      repeat (6) @(posedge aclk);
      chk_pin(first_pg, 1'b0);
      wr(8'h5C, 32'h02, OK);
      // Rise delay on the second output, with slow monitors.
      wr(8'h68, 32'hBF, OK);
      lag <= 4'h4;
      src(7'h7D, 12);
      chk_pin(second_pg, 1'b0);
      src(7'h7F, 12);
      chk_pin(second_pg, 1'b0);
      repeat (25) @(posedge aclk);
      chk_pin(second_pg, 1'b1);
      // Latched gating and inverted polarity on the second output.
      wr(8'h5C, 32'h42, OK);
      repeat (3) @(posedge aclk);
      chk_pin(second_pg, 1'b0);
      wr(8'h5C, 32'h12, OK);
      repeat (25) @(posedge aclk);
      chk_pin(second_pg, 1'b0);
      wr(8'h5C, 32'h02, OK);
      wr(8'h64, 32'h02, OK);
      wr(8'h6C, 32'h02, OK);
      rd(8'h6C, 32'h00, OK);
      // A second reset returns the second enable register to its reset value.
      aresetn <= 1'b0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(8'h68, 32'h3F, OK);
      conclude();
   end
endmodule
